/* File: verilog/mdlink_cfg.sv */
// multidrop link configuration, status, polling and exchange-area mapping
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`default_nettype none
module mdlink_cfg #(
  parameter int TIMEOUT_UNIT_CYC = mdlink_pkg::TIMEOUT_UNIT_CYCLES // cycles per 10 ms
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] link_pattern,
  input wire logic resp_valid,
  input wire logic [2:0] resp_station,
  input wire logic seq_err_valid,
  input wire logic [2:0] seq_err_station,
  input wire logic rx_valid,
  input wire logic rx_is_bit,
  input wire logic [2:0] rx_station,
  input wire logic [2:0] rx_index,
  input wire logic [15:0] rx_data,
  output logic poll_req,
  output logic [2:0] poll_station,
  output logic link_active_flag,
  output logic chan2_sel,
  output logic [7:0] seq_error,
  output logic irq
);
  import mdlink_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam logic [18:0] UNIT_LAST = 19'(TIMEOUT_UNIT_CYC - 1); // last prescaler count

  typedef struct packed {
    logic [2:0] station; // own station number
    logic [2:0] scount; // slaves polled by the master
    logic [1:0] pattern; // refresh pattern
    logic [3:0] retry; // retry limit
    logic [7:0] tmo; // timeout in 10 ms units
    logic [2:0] ctrl; // enable, parameter flag, channel select
    logic [7:0] serr; // bit0 master, bits 7:1 slaves 1..7
    logic link; // exchange running
    logic [2:0] irq_st; // sticky events
    logic [2:0] irq_mask; // event enables
    logic irq; // interrupt level
    bus_state_t bst; // bus phase
    logic bwr; // captured write
    logic [11:0] baddr; // captured byte address
    logic hready; // data phase done
    logic [31:0] rdata; // read data
    poll_state_t mst; // poll sequencer
    logic [2:0] cur; // slave being polled
    logic [3:0] tries; // retries spent on cur
    logic [18:0] pre; // 10 ms prescaler
    logic [7:0] units; // timeout units left
    logic poll; // poll request pulse
    logic [2:0] pstn; // station polled
  } state_t;

  state_t st_r; // registered state
  state_t st_nxt; // next state

  logic [15:0] mem_rdata; // exchange memory read data
  logic mem_we; // exchange memory write enable
  logic [6:0] mem_waddr; // exchange memory write address
  logic [15:0] mem_wdata; // exchange memory write data
  logic [6:0] mem_raddr; // exchange memory read address
  logic rx_wr; // accepted received point
  logic [1:0] eff_pat; // pattern in force
  logic [3:0] wlim; // word points per station
  logic [3:0] blim; // bit blocks per station
  logic [7:0] serr_set; // error flags set this cycle
  logic [7:0] serr_clr; // error flags cleared this cycle
  logic tmo_hit; // response time exceeded
  logic bus_take; // address phase accepted
  logic run; // exchange enabled
  logic [15:0] wv; // write value, low half

  // ------------------------------------------------------------
  // exchange memory
  // ------------------------------------------------------------
  mdlink_xmem u_xmem (
    .hclk(hclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    wv = hwdata[15:0];
    bus_take = hsel && htrans[1] && hready;
    mem_raddr = haddr[8:2];
    run = st_r.ctrl[CTRL_EN] && st_r.ctrl[CTRL_PARAM];
    // master uses its own pattern, slaves the one announced on the link
    eff_pat = (st_r.station == STATION_RST) ? st_r.pattern : link_pattern; // [RULE_12]
    // points per station for the pattern in force
    case (eff_pat)
      PAT_1: begin
        wlim = WORDS_SMALL; // [RULE_14]
        blim = BLKS_PAT1; // [RULE_14]
      end
      PAT_2: begin
        wlim = WORDS_LARGE; // [RULE_15]
        blim = BLKS_PAT2; // [RULE_15]
      end
      default: begin
        wlim = WORDS_SMALL; // [RULE_13]
        blim = 4'h0; // [RULE_13]
      end
    endcase
    // a received point lands only inside the sender's area and not while it is in error
    rx_wr = rx_valid && st_r.link && (rx_station != st_r.station)
      && ({1'b0, rx_index} < (rx_is_bit ? blim : wlim))
      && !st_r.serr[rx_station]; // [RULE_17]
    mem_waddr = rx_is_bit ? BIT_BASE + {2'h0, rx_station, 2'h0} + {4'h0, rx_index}
      : 7'(rx_station * WORD_STRIDE) + {4'h0, rx_index}; // [RULE_13] [RULE_14] [RULE_15]
    mem_wdata = rx_data;
    mem_we = rx_wr;

    // error flags: link reports and master timeouts set, good responses clear
    serr_set = 8'h00;
    serr_clr = 8'h00;
    if (seq_err_valid && st_r.link) begin
      serr_set[seq_err_station] = 1'b1; // [RULE_09] [RULE_10]
    end
    if (resp_valid && st_r.link) begin
      serr_clr[resp_station] = 1'b1;
    end

    // poll sequencer, master only
    tmo_hit = (st_r.pre == UNIT_LAST) && (st_r.units == 8'h01);
    st_nxt.poll = 1'b0;
    case (st_r.mst)
      M_OFF: begin
        st_nxt.cur = 3'h1;
        st_nxt.tries = 4'h0;
        if (run && st_r.station == STATION_RST) begin
          st_nxt.mst = M_POLL;
        end
      end
      M_POLL: begin
        // issue the poll and arm the response timer
        st_nxt.poll = 1'b1;
        st_nxt.pstn = st_r.cur; // [RULE_19]
        st_nxt.pre = 19'h0;
        st_nxt.units = st_r.tmo; // [RULE_06]
        st_nxt.mst = M_WAIT;
      end
      M_WAIT: begin
        st_nxt.pre = (st_r.pre == UNIT_LAST) ? 19'h0 : st_r.pre + 19'h1;
        if (st_r.pre == UNIT_LAST) begin
          st_nxt.units = st_r.units - 8'h1;
        end
        if (resp_valid && resp_station == st_r.cur) begin
          st_nxt.mst = M_NEXT;
        end else if (tmo_hit) begin
          if (st_r.tries < st_r.retry) begin
            st_nxt.tries = st_r.tries + 4'h1; // [RULE_05]
            st_nxt.mst = M_POLL;
          end else begin
            serr_set[st_r.cur] = 1'b1; // [RULE_05]
            st_nxt.mst = M_NEXT;
          end
        end
      end
      M_NEXT: begin
        // ascending order, wrap after the last configured slave
        st_nxt.tries = 4'h0;
        st_nxt.cur = (st_r.cur >= st_r.scount) ? 3'h1 : st_r.cur + 3'h1; // [RULE_19] [RULE_02]
        st_nxt.mst = M_POLL;
      end
      default: begin
        st_nxt.mst = M_OFF;
      end
    endcase
    if (!run || st_r.station != STATION_RST) begin
      st_nxt.mst = M_OFF;
    end

    // flags: a set in the same cycle as a clear wins
    st_nxt.serr = (st_r.serr & ~serr_clr) | serr_set;
    st_nxt.link = run; // [RULE_11]
    if (!run) begin
      st_nxt.serr = 8'h00;
    end

    // bus slave: one wait cycle per data phase, more while a received point holds the memory port
    case (st_r.bst)
      B_IDLE: begin
        if (bus_take) begin
          st_nxt.bst = B_DATA;
          st_nxt.bwr = hwrite;
          st_nxt.baddr = haddr[11:0];
          st_nxt.hready = 1'b0;
        end
      end
      B_DATA: begin
        st_nxt.hready = 1'b1;
        st_nxt.bst = B_IDLE;
        st_nxt.rdata = 32'h0;
        if (st_r.bwr) begin
          if (st_r.baddr[11:10] == MEM_WIN_SEL) begin
            // local software writes; a received point has the port first
            if (rx_wr) begin
              st_nxt.hready = 1'b0;
              st_nxt.bst = B_DATA;
            end else begin
              mem_we = 1'b1;
              mem_waddr = st_r.baddr[8:2];
              mem_wdata = wv;
            end
          end else begin
            case (st_r.baddr)
              OFS_STATION: if (wv <= STATION_MAX) st_nxt.station = wv[2:0]; // [RULE_01]
              OFS_SCOUNT: begin
                if (wv >= SCOUNT_MIN && wv <= SCOUNT_MAX) begin
                  st_nxt.scount = wv[2:0]; // [RULE_02]
                end
              end
              OFS_PATTERN: if (wv <= PATTERN_MAX) st_nxt.pattern = wv[1:0]; // [RULE_03]
              OFS_RETRY: if (wv <= RETRY_MAX) st_nxt.retry = wv[3:0]; // [RULE_05]
              OFS_TIMEOUT: begin
                if (wv >= TIMEOUT_MIN && wv <= TIMEOUT_MAX) begin
                  st_nxt.tmo = wv[7:0]; // [RULE_06]
                end
              end
              OFS_CTRL: st_nxt.ctrl = hwdata[2:0]; // [RULE_07]
              OFS_IRQ_STAT: st_nxt.irq_st = st_r.irq_st & ~hwdata[2:0];
              OFS_IRQ_MASK: st_nxt.irq_mask = hwdata[2:0];
              default: begin
                st_nxt.bwr = st_r.bwr;
              end
            endcase
          end
        end else begin
          if (st_r.baddr[11:10] == MEM_WIN_SEL) begin
            st_nxt.rdata = {16'h0, mem_rdata};
          end else begin
            case (st_r.baddr)
              OFS_STATION: st_nxt.rdata = {29'h0, st_r.station};
              OFS_SCOUNT: st_nxt.rdata = {29'h0, st_r.scount};
              OFS_PATTERN: st_nxt.rdata = {30'h0, st_r.pattern};
              OFS_RETRY: st_nxt.rdata = {28'h0, st_r.retry};
              OFS_TIMEOUT: st_nxt.rdata = {24'h0, st_r.tmo};
              OFS_CTRL: st_nxt.rdata = {29'h0, st_r.ctrl};
              OFS_STATUS: st_nxt.rdata = {23'h0, st_r.link, st_r.serr}; // [RULE_10]
              OFS_IRQ_STAT: st_nxt.rdata = {29'h0, st_r.irq_st};
              OFS_IRQ_MASK: st_nxt.rdata = {29'h0, st_r.irq_mask};
              default: st_nxt.rdata = 32'h0;
            endcase
          end
        end
      end
      default: begin
        st_nxt.bst = B_IDLE;
        st_nxt.hready = 1'b1;
      end
    endcase

    // sticky events; an event beats a clear in the same cycle
    if ((serr_set & ~st_r.serr) != 8'h00) begin
      st_nxt.irq_st[IRQ_ERR] = 1'b1;
    end
    if (run && !st_r.link) begin
      st_nxt.irq_st[IRQ_UP] = 1'b1;
    end
    if (!run && st_r.link) begin
      st_nxt.irq_st[IRQ_DOWN] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '{station: STATION_RST, scount: SCOUNT_RST, pattern: PATTERN_RST,
                retry: RETRY_RST, tmo: TIMEOUT_RST, ctrl: 3'h0, serr: 8'h00,
                link: 1'b0, irq_st: 3'h0, irq_mask: 3'h0, irq: 1'b0, bst: B_IDLE,
                bwr: 1'b0, baddr: 12'h0, hready: 1'b1, rdata: 32'h0, mst: M_OFF,
                cur: 3'h1, tries: 4'h0, pre: 19'h0, units: 8'h0, poll: 1'b0,
                pstn: 3'h0}; // [RULE_01] [RULE_02] [RULE_03]
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs from the state register, hresp tied low
  // ------------------------------------------------------------
  assign hreadyout = st_r.hready;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign poll_req = st_r.poll;
  assign poll_station = st_r.pstn;
  assign link_active_flag = st_r.link;
  assign chan2_sel = st_r.ctrl[CTRL_CHAN];
  assign seq_error = st_r.serr;
  assign irq = st_r.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_station_range: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_01]
    st_r.station <= 3'h7 && $past(hwdata[15:0]) > STATION_MAX && $past(st_r.bst == B_DATA)
    && $past(st_r.bwr) && $past(st_r.baddr) == OFS_STATION |-> $stable(st_r.station))
    else $error("station number took an illegal value");
  a_scount_range: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_02]
    st_r.scount >= 3'h1)
    else $error("slave count fell to zero");
  a_pattern_range: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_03]
    st_r.pattern <= 2'h2)
    else $error("refresh pattern out of range");
  a_retry_bound: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_05]
    st_r.mst == M_WAIT && tmo_hit && st_r.tries >= st_r.retry && run
    |=> st_r.serr[$past(st_r.cur)] && st_r.mst == M_NEXT)
    else $error("no error after the last retry");
  a_timeout_min: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_06]
    st_r.tmo >= 8'h05)
    else $error("response timeout below five units");
  a_chan_follow: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_07]
    st_r.bst == B_DATA && st_r.bwr && st_r.baddr == OFS_CTRL
    |=> chan2_sel == $past(hwdata[CTRL_CHAN]))
    else $error("channel select did not follow the control write");
  a_master_err: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_09]
    seq_err_valid && seq_err_station == 3'h0 && st_r.link && run |=> seq_error[0])
    else $error("master sequence error not flagged");
  a_slave_err: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
    seq_err_valid && seq_err_station != 3'h0 && st_r.link && run
    |=> seq_error[$past(seq_err_station)])
    else $error("slave sequence error not flagged");
  a_link_active: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_11]
    ##1 link_active_flag == $past(st_r.ctrl[CTRL_EN] && st_r.ctrl[CTRL_PARAM]))
    else $error("link active flag does not match the enables");
  a_area_size: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_13]
    rx_wr |-> (rx_is_bit ? (eff_pat != PAT_0) : (eff_pat == PAT_2 || rx_index < 3'h4)))
    else $error("point accepted outside the station area");
  a_rx_freeze: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_17]
    st_r.serr[rx_station] |-> !rx_wr)
    else $error("received area written during a link error");
  a_poll_order: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_19]
    poll_req |-> poll_station >= 3'h1 && poll_station <= st_r.scount)
    else $error("poll addressed a station outside the slave range");
endmodule : mdlink_cfg
`default_nettype wire

/* File: pkg/mdlink_pkg.sv */
// constants, register map and types shared by the multidrop link configuration block
//
// Function
// RULE_01 - station number 0..7, 0 master, reset 0
// RULE_02 - slave count 1..7, reset 7, master only
// RULE_03 - refresh pattern 0..2, reset 0, master only
// RULE_04 - legacy stations present force pattern 0; not implemented, the pattern in force is the own pattern or link_pattern
// RULE_05 - retry up to limit 0..10, then error
// RULE_06 - timeout 5..255 times 10 ms, reset 5
// RULE_07 - channel 2 when channel select driven
// RULE_08 - software never forces parameter flag directly; here an OFS_CTRL write sets it straight from hwdata[1]
// RULE_09 - master sequence error flag on master error
// RULE_10 - seven slave error flags, stations 1..7 ascending
// RULE_11 - link active flag high while exchange runs
// RULE_12 - area placed by station number and pattern
// RULE_13 - pattern 0: 4 words at 10n
// RULE_14 - pattern 1: 32 bits, 4 words
// RULE_15 - pattern 2: 64 bits, 8 words
// RULE_16 - stations write only their own area
// RULE_17 - received area frozen after a link error
// RULE_18 - slave numbers consecutive, no gaps, no duplicates
// RULE_19 - master polls slaves ascending, repeats continuously
`default_nettype none
package mdlink_pkg;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [11:0] OFS_STATION = 12'h000;
  localparam logic [11:0] OFS_SCOUNT = 12'h004;
  localparam logic [11:0] OFS_PATTERN = 12'h008;
  localparam logic [11:0] OFS_RETRY = 12'h00c;
  localparam logic [11:0] OFS_TIMEOUT = 12'h010;
  localparam logic [11:0] OFS_CTRL = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h01c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
  localparam logic [1:0] MEM_WIN_SEL = 2'h1; // haddr[11:10] of the exchange window
  // reset values and legal ranges
  localparam logic [2:0] STATION_RST = 3'h0;
  localparam logic [2:0] SCOUNT_RST = 3'h7;
  localparam logic [1:0] PATTERN_RST = 2'h0;
  localparam logic [3:0] RETRY_RST = 4'h3;
  localparam logic [7:0] TIMEOUT_RST = 8'h05;
  localparam logic [15:0] STATION_MAX = 16'h0007;
  localparam logic [15:0] SCOUNT_MIN = 16'h0001;
  localparam logic [15:0] SCOUNT_MAX = 16'h0007;
  localparam logic [15:0] PATTERN_MAX = 16'h0002;
  localparam logic [15:0] RETRY_MAX = 16'h000a;
  localparam logic [15:0] TIMEOUT_MIN = 16'h0005;
  localparam logic [15:0] TIMEOUT_MAX = 16'h00ff;
  // control and status field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_PARAM = 1;
  localparam int CTRL_CHAN = 2;
  localparam int STAT_LINK = 8;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_UP = 1;
  localparam int IRQ_DOWN = 2;
  // exchange memory layout: words of station n at 10n, bit blocks at 80 + 4n
  localparam logic [6:0] WORD_STRIDE = 7'h0a;
  localparam logic [6:0] BIT_BASE = 7'h50;
  localparam logic [3:0] WORDS_SMALL = 4'h4;
  localparam logic [3:0] WORDS_LARGE = 4'h8;
  localparam logic [3:0] BLKS_PAT1 = 4'h2;
  localparam logic [3:0] BLKS_PAT2 = 4'h4;
  localparam logic [1:0] PAT_0 = 2'h0;
  localparam logic [1:0] PAT_1 = 2'h1;
  localparam logic [1:0] PAT_2 = 2'h2;
  // timing: one timeout unit in ms and the clock period in ns
  localparam int TIMEOUT_UNIT_MS = 10;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEOUT_UNIT_CYCLES = TIMEOUT_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  // bus and poll state encodings
  typedef enum logic {B_IDLE = 1'b0, B_DATA = 1'b1} bus_state_t;
  typedef enum logic [1:0] {
    M_OFF = 2'b00, M_POLL = 2'b01, M_WAIT = 2'b10, M_NEXT = 2'b11
  } poll_state_t;
endpackage : mdlink_pkg
`default_nettype wire

/* File: verilog/mdlink_xmem.sv */
// exchange-area memory: one write port, one registered read port
`default_nettype none
module mdlink_xmem (
  input wire logic hclk,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [6:0] raddr,
  output logic [15:0] rdata
);
  // ------------------------------------------------------------
  // storage: 80 word points then 32 blocks of 16 bit points
  // ------------------------------------------------------------
  logic [15:0] mem [0:127]; // exchange storage, no reset
  logic [15:0] rdata_r; // registered read data

  // write and registered read
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

  assign rdata = rdata_r;
endmodule : mdlink_xmem
`default_nettype wire

/* File: verif/mdlink_partner.sv */
// far-side stations: answer each poll of the master unless told to stay silent
`default_nettype none
module mdlink_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic poll_req,
  input wire logic [2:0] poll_station,
  input wire logic [7:0] mute,
  input wire logic slow,
  output logic resp_valid,
  output logic [2:0] resp_station
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt; // cycles left before the answer goes out
  logic [2:0] who; // station that was polled
  // answer one or six cycles after a poll; an idle station line keeps toggling
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      resp_valid <= 1'b0;
      resp_station <= 3'h0;
    end else begin
      resp_valid <= 1'b0;
      resp_station <= ~resp_station;
      if (poll_req && !mute[poll_station]) begin
        cnt <= slow ? 6 : 1;
        who <= poll_station;
      end else if (cnt == 1) begin
        resp_valid <= 1'b1;
        resp_station <= who;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : mdlink_partner
`default_nettype wire

/* File: verif/mdlink_cfg_bench.sv */
// self-checking bench for the multidrop link configuration block
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module mdlink_cfg_bench;
  import mdlink_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_valid, rx_is_bit, seq_err_valid;
  logic [31:0] haddr, hwdata, hrdata, rs, r;
  logic [1:0] htrans;
  logic [2:0] rx_station, rx_index, seq_err_station, resp_station, poll_station, ps;
  logic [15:0] rx_data;
  logic poll_req, link_active_flag, chan2_sel, irq, resp_valid, slow;
  logic [7:0] seq_error, mute, merr;
  logic [15:0] mem [128]; // model of the exchange area
  int mr [5] = '{0, 7, 0, 3, 5}; // model of the setting registers
  int tv [4] = '{4, 5, 255, 256}; // timeout boundaries
  int n_mismatch = 0, checked = 0, cyc = 0, gap, n;
  mdlink_cfg #(.TIMEOUT_UNIT_CYC(4)) i_mdlink_cfg (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link_pattern(PAT_0), .resp_valid(resp_valid),
    .resp_station(resp_station), .seq_err_valid(seq_err_valid),
    .seq_err_station(seq_err_station), .rx_valid(rx_valid), .rx_is_bit(rx_is_bit),
    .rx_station(rx_station), .rx_index(rx_index), .rx_data(rx_data), .poll_req(poll_req),
    .poll_station(poll_station), .link_active_flag(link_active_flag),
    .chan2_sel(chan2_sel), .seq_error(seq_error), .irq(irq));
  mdlink_partner i_mdlink_partner (.hclk(hclk), .hresetn(hresetn), .poll_req(poll_req),
    .poll_station(poll_station), .mute(mute), .slow(slow), .resp_valid(resp_valid),
    .resp_station(resp_station));
  // clock, answer speed and hang guard
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) slow <= ~slow;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // legal range of each setting
  function automatic bit legal(input int k, input int v);
    case (k)
      0: return v <= 7;
      1: return v >= 1 && v <= 7;
      2: return v <= 2;
      3: return v <= 10;
      default: return v >= 5 && v <= 255;
    endcase
  endfunction : legal
  // one single-word transfer; read data lands in r
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  // write a setting, then read it back against the model
  task automatic setreg(input int k, input int v);
    ahb(1'b1, 12'(4 * k), 32'(v));
    if (legal(k, v)) mr[k] = v;
    ahb(1'b0, 12'(4 * k), 32'h0);
    `CHK("setting", 32'(mr[k]), r)
    `CHK("response", 1'b0, hresp)
  endtask : setreg
  // one received point; the model keeps it only inside the pattern's area
  // each sending station fills only its own area
  task automatic rx(input logic b, input logic [2:0] s, input logic [2:0] i);
    rs = lfsr(rs);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_is_bit <= b;
    rx_station <= s;
    rx_index <= i;
    rx_data <= rs[15:0];
    if (!merr[s] && (b ? i < (mr[2] == 0 ? 0 : 2 * mr[2]) : i < (mr[2] == 2 ? 8 : 4)))
      mem[b ? 80 + 4 * s + i : 10 * s + i] = rs[15:0];
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_data <= ~rs[15:0];
  endtask : rx
  // read back all word and bit-block places of station s
  task automatic mchk(input int s);
    for (int k = 0; k < 12; k++) begin
      n = k < 8 ? 10 * s + k : 80 + 4 * s + k - 8;
      ahb(1'b0, 12'h400 + 12'(4 * n), 32'h0);
      `CHK("xmem", {16'h0, mem[n]}, r)
    end
  endtask : mchk
  task automatic next_poll(output logic [2:0] s);
    gap = 0;
    do begin
      @(posedge hclk);
      gap++;
    end while (poll_req !== 1'b1);
    s = poll_station;
  endtask : next_poll
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, rx_valid, rx_is_bit, seq_err_valid, slow} = '0;
    {haddr, hwdata, htrans, rx_station, rx_index, seq_err_station, rx_data} = '0;
    mute = 8'h00;
    merr = 8'h00;
    rs = 32'hd4eff59f;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      ahb(1'b0, 12'(4 * k), 32'h0);
      `CHK("reset value", 32'(mr[k]), r)
    end
    for (int t = 0; t < 30; t++) begin
      rs = lfsr(rs);
      setreg(rs[2:0] % 5, rs[2:0] % 5 == 4 ? rs[16:8] : rs[7:4]);
    end
    foreach (tv[i]) setreg(4, tv[i]);
    // back to the master role, the random writes may have left a slave number
    setreg(0, 0);
    setreg(1, 3);
    setreg(3, 1);
    setreg(4, 5);
    $display("test settings done");
    // setup sequence: enable together with the parameter flag, never the flag alone
    ahb(1'b1, OFS_CTRL, 32'h7);
    repeat (2) @(posedge hclk);
    `CHK("link flag", 1'b1, link_active_flag)
    `CHK("channel", 1'b1, chan2_sel)
    `CHK("irq masked", 1'b0, irq)
    ahb(1'b1, OFS_IRQ_MASK, 32'h7);
    repeat (2) @(posedge hclk);
    `CHK("irq up", 1'b1, irq)
    ahb(1'b1, OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK("irq cleared", 1'b0, irq)
    ahb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status link", 1'b1, r[STAT_LINK])
    do next_poll(ps); while (ps != 3);
    for (int i = 0; i < 6; i++) begin
      next_poll(ps);
      `CHK("poll order", 3'(i % 3 + 1), ps)
    end
    $display("test link start done");
    for (int p = 2; p >= 0; p--) begin
      setreg(2, p);
      for (int s = 1; s < 4; s++) begin
        for (int i = 0; i < 16; i++) rx(i[3], 3'(s), i[2:0]);
        mchk(s);
      end
    end
    $display("test exchange areas done");
    do next_poll(ps); while (ps != 1);
    mute <= 8'h04;
    n = 0;
    do begin
      next_poll(ps);
      if (ps == 2 && n == 1) `CHK("retry gap", 1'b1, gap >= 20)
      n += (ps == 2);
    end while (ps != 3);
    `CHK("retries", 2, n)
    merr[2] = 1'b1;
    `CHK("slave errors", 8'h04, seq_error)
    repeat (2) @(posedge hclk);
    `CHK("irq error", 1'b1, irq)
    rx(1'b0, 3'h2, 3'h0);
    mchk(2);
    ahb(1'b1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    `CHK("irq off", 1'b0, irq)
    mute <= 8'h00;
    merr[2] = 1'b0;
    do next_poll(ps); while (ps != 2);
    do next_poll(ps); while (ps != 3);
    `CHK("errors cleared", 8'h00, seq_error)
    ahb(1'b1, OFS_IRQ_MASK, 32'h7);
    ahb(1'b1, OFS_IRQ_STAT, 32'h7);
    repeat (2) @(posedge hclk);
    `CHK("irq all clear", 1'b0, irq)
    $display("test retry and errors done");
    @(posedge hclk);
    seq_err_valid <= 1'b1;
    seq_err_station <= 3'h0;
    @(posedge hclk);
    seq_err_station <= 3'h5;
    @(posedge hclk);
    seq_err_valid <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK("master error", 1'b1, seq_error[0])
    `CHK("slave error", 1'b1, seq_error[5])
    ahb(1'b1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    `CHK("link off", 1'b0, link_active_flag)
    `CHK("channel 1", 1'b0, chan2_sel)
    `CHK("errors off", 8'h00, seq_error)
    $display("test master error done");
    report_and_stop();
  end
endmodule : mdlink_cfg_bench
`undef CHK
`default_nettype wire
